// ---- design/sslf_pkg.sv ----
package sslf_pkg;
  // downstream frame layout
  localparam logic [4:0] FRAME_BITS = 5'h11; // active phase length in link clock pulses
  localparam logic [4:0] CNT_SAT = 5'h1F; // bit counter saturates here
  localparam int SEL_BIT = 0; // first bit received: frame kind
  localparam logic DATA_SEL = 1'b0; // selection value of a data frame
  localparam int CTRL_W = 17; // output_stage_control width
  localparam logic [16:0] CTRL_RESET = 17'h1FFFE; // all frame stages off after reset
  localparam logic [15:0] CTRL_ALL_OFF = 16'hFFFF; // stage bits forced off on link loss
  localparam int CMD_W = 16; // command frame payload, bits 1..16
  localparam int HALF_BITS = 8; // stage bits per half of a data frame
  localparam int EVEN_BASE = 9; // first frame bit of the even-stage half
  localparam int STAGE_N = 18;
  // stage numbers driven by frame bits 1..8 and 9..16
  localparam int ODD_STAGE [8] = '{1, 3, 5, 7, 9, 11, 13, 17};
  localparam int EVEN_STAGE [8] = '{2, 4, 6, 8, 10, 12, 14, 18};
  localparam int DLY_STAGE_A = 15; // stages reached only by the dedicated write command
  localparam int DLY_STAGE_B = 16;
  // upstream frame layout
  localparam logic [3:0] UP_FRAME_BITS = 4'hD;
  localparam logic UP_START = 1'b0;
  localparam logic [2:0] UP_STOP = 3'h7;
  localparam logic UP_IDLE = 1'b1; // line level between frames
  localparam int DIV_W = 4; // upstream divider setting width
  // timing
  localparam int CLK_MHZ = 100; // I_CLK rate
  localparam int SUPERV_TIME_US = 500; // link supervision time
  localparam int SUPERV_CYCLES = SUPERV_TIME_US * CLK_MHZ;
  // buffering
  localparam int CMD_FIFO_DEPTH = 32;
endpackage

// ---- design/sslf_fifo.sv ----
`timescale 1ns/1ps
// simple synchronous fifo, registered flags
module sslf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // storage
    logic [AW-1:0] wr; // write index
    logic [AW-1:0] rd; // read index
    logic [AW:0] cnt; // words held
    logic in_ready; // not full
    logic out_valid; // not empty
  } sslf_fifo_t;

  sslf_fifo_t q, d;
  logic push, pop; // handshakes of this cycle

  assign push = i_in_valid & q.in_ready;
  assign pop = i_out_ready & q.out_valid;
  assign o_in_ready = q.in_ready;
  assign o_out_valid = q.out_valid;
  assign o_out_data = q.mem[q.rd];

  // pointer and count update; flags follow next count so they stay honest
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = i_in_data;
      d.wr = (q.wr == LAST_IDX) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == LAST_IDX) ? '0 : q.rd + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
    d.in_ready = (d.cnt != FULL_CNT);
    d.out_valid = (d.cnt != '0);
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.in_ready <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule // sslf_fifo

// ---- design/sslf_link.sv ----
// Operation
// - data frame starts with zero selection bit
// - bits 1-8 odd stages, 9-16 even stages
// - no parity check on data frames
// - control bit one means stage off
// - stages 15 and 16 not frame controlled
// - accepted data frame writes output stage control
// - upstream output high means logic one
// - upstream rate divides downstream clock, configurable
// - upstream frame: start, eight data, parity, stops
// - upstream parity makes even ones count
// - start bit follows read within response time
// - read ignored while upstream transfer busy
// - new read only after last stop bit
// - writes and data frames run while busy
// - in-flight response keeps pre-write content
// - upstream bits timed by downstream clock
// - link logic halts without downstream clock
// - supervision timed independently of link clock
// - frame valid only with 17 clock pulses
// - data sampled on falling clock, select low
// - valid data frame restarts supervision; expiry switches off
`timescale 1ns/1ps
module sslf_link #(
  parameter int SUPERV_CYCLES = sslf_pkg::SUPERV_CYCLES,
  parameter int FIFO_DEPTH = sslf_pkg::CMD_FIFO_DEPTH
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // link pins
  input wire logic I_DOWNSTREAM_CLOCK_IN,
  input wire logic I_FRAME_SELECT_SYNC,
  input wire logic I_SERIAL_DATA_IN,
  output logic O_UPSTREAM_SERIAL_OUT,
  // received command frames to the command decoder
  output logic O_CMD_VALID,
  input wire logic I_CMD_READY,
  output logic [sslf_pkg::CMD_W-1:0] O_CMD_WORD,
  output logic O_CMD_FIFO_READY,
  // read requests from the command decoder
  input wire logic I_READ_REQ,
  input wire logic [7:0] I_READ_BYTE,
  input wire logic [sslf_pkg::DIV_W-1:0] I_UP_CLK_DIV,
  output logic O_UP_BUSY,
  // stage control
  input wire logic [1:0] I_DELAYED_STAGES_OFF,
  output logic [sslf_pkg::STAGE_N-1:0] O_STAGE_OFF,
  output logic [sslf_pkg::CTRL_W-1:0] O_OUTPUT_STAGE_CONTROL,
  // supervision
  input wire logic I_MON_FAIL_CLR,
  output logic O_LINK_MON_FAIL
);
  localparam int SUP_W = $clog2(SUPERV_CYCLES + 1);
  localparam logic [SUP_W-1:0] SUP_MAX = SUP_W'(SUPERV_CYCLES);
  localparam logic [SUP_W-1:0] SUP_LAST = SUP_W'(SUPERV_CYCLES - 1);

  typedef struct packed {
    logic clk_s1, clk_s2, clk_prev; // link clock synchroniser and edge history
    logic sel_s1, sel_s2, sel_prev; // select synchroniser and edge history
    logic din_s1, din_s2; // serial data synchroniser
    logic [4:0] bit_cnt; // falling edges seen in the active phase
    logic [sslf_pkg::CTRL_W-1:0] shift; // received bits, first bit at 0
    logic [sslf_pkg::CTRL_W-1:0] ctrl; // output_stage_control
    logic [sslf_pkg::STAGE_N-1:0] stage_off; // per-stage off command
    logic [SUP_W-1:0] sup_cnt; // supervision timer
    logic mon_fail; // sticky link-monitor failure
    logic cmd_push; // command frame waiting for the fifo
    logic [sslf_pkg::CMD_W-1:0] cmd_word; // its payload
    logic tx_busy; // upstream frame in flight
    logic [12:0] tx_shift; // remaining upstream bits, next at 0
    logic [3:0] bits_left; // upstream bits still to start
    logic [sslf_pkg::DIV_W-1:0] div_set; // divider latched at read accept
    logic [sslf_pkg::DIV_W-1:0] div_cnt; // link edges until next bit
    logic upstream_serial_out; // upstream line
  } sslf_state_t;

  sslf_state_t q, d;
  logic link_fall; // falling edge of the synchronised link clock
  logic sel_rise; // end of an active phase
  logic len_ok; // exactly 17 pulses seen
  logic data_ok; // accepted data frame this cycle
  logic sup_expire; // supervision timer runs out this cycle
  logic read_ok; // read request taken this cycle
  logic tx_tick; // upstream bit boundary this cycle
  logic fifo_in_ready; // fifo space, registered in the fifo

  // edges seen after the second synchroniser stage only
  assign link_fall = q.clk_prev & ~q.clk_s2;
  assign sel_rise = q.sel_s2 & ~q.sel_prev;
  assign len_ok = (q.bit_cnt == sslf_pkg::FRAME_BITS);
  // no parity, only the length and the selection bit decide
  assign data_ok = sel_rise && len_ok && (q.shift[sslf_pkg::SEL_BIT] == sslf_pkg::DATA_SEL);
  // supervision counts on I_CLK, not on link edges, so a dead link still expires
  assign sup_expire = (q.sup_cnt == SUP_LAST);
  // busy refuses reads; idle again only after the last stop bit has run
  assign read_ok = I_READ_REQ && !q.tx_busy;
  // upstream bits move only on link edges: no clock, no progress
  assign tx_tick = q.tx_busy && link_fall && (q.div_cnt == '0);

  // next-state logic
  always_comb begin
    d = q;
    // two-flop synchronisers for the three link pins
    d.clk_s1 = I_DOWNSTREAM_CLOCK_IN;
    d.clk_s2 = q.clk_s1;
    d.clk_prev = q.clk_s2;
    d.sel_s1 = I_FRAME_SELECT_SYNC;
    d.sel_s2 = q.sel_s1;
    d.sel_prev = q.sel_s2;
    d.din_s1 = I_SERIAL_DATA_IN;
    d.din_s2 = q.din_s1;
    d.cmd_push = 1'b0;
    // sample on the falling edge only while select is low
    if (link_fall && !q.sel_s2) begin
      d.shift = {q.din_s2, q.shift[sslf_pkg::CTRL_W-1:1]};
      if (q.bit_cnt != sslf_pkg::CNT_SAT) begin
        d.bit_cnt = q.bit_cnt + 1'b1;
      end
    end
    // supervision timer, saturating so it expires once
    if (q.sup_cnt != SUP_MAX) begin
      d.sup_cnt = q.sup_cnt + 1'b1;
    end
    // software clear first, so an expiry in the same cycle wins
    if (I_MON_FAIL_CLR) begin
      d.mon_fail = 1'b0;
    end
    if (sup_expire) begin
      d.mon_fail = 1'b1;
      d.ctrl[sslf_pkg::CTRL_W-1:1] = sslf_pkg::CTRL_ALL_OFF;
    end
    // end of an active phase: judge length and kind, ignore the rest
    if (sel_rise) begin
      d.bit_cnt = '0;
      if (data_ok) begin
        d.ctrl = q.shift;
        d.sup_cnt = '0;
      end else if (len_ok) begin
        // a full fifo drops the frame like a bad one; its ready flag shows it
        d.cmd_push = 1'b1;
        d.cmd_word = q.shift[sslf_pkg::CTRL_W-1:1];
      end
    end
    // frame bit order to stage number; one means off
    for (int k = 0; k < sslf_pkg::HALF_BITS; k++) begin
      d.stage_off[sslf_pkg::ODD_STAGE[k]-1] = q.ctrl[k+1];
      d.stage_off[sslf_pkg::EVEN_STAGE[k]-1] = q.ctrl[k+sslf_pkg::EVEN_BASE];
    end
    // delayed stages come from the write command path only
    d.stage_off[sslf_pkg::DLY_STAGE_A-1] = I_DELAYED_STAGES_OFF[0];
    d.stage_off[sslf_pkg::DLY_STAGE_B-1] = I_DELAYED_STAGES_OFF[1];
    // upstream transmitter
    if (read_ok) begin
      d.tx_busy = 1'b1;
      // byte captured now, so later writes cannot change the frame in flight
      d.tx_shift = {sslf_pkg::UP_STOP, ^I_READ_BYTE, I_READ_BYTE, sslf_pkg::UP_START};
      d.bits_left = sslf_pkg::UP_FRAME_BITS;
      d.div_set = I_UP_CLK_DIV;
      d.div_cnt = '0; // start bit on the next link edge
    end else if (q.tx_busy && link_fall) begin
      if (q.div_cnt != '0) begin
        d.div_cnt = q.div_cnt - 1'b1;
      end else if (q.bits_left == '0) begin
        // last stop bit has had its full period
        d.tx_busy = 1'b0;
        d.upstream_serial_out = sslf_pkg::UP_IDLE;
      end else begin
        d.upstream_serial_out = q.tx_shift[0];
        d.tx_shift = {sslf_pkg::UP_IDLE, q.tx_shift[12:1]};
        d.bits_left = q.bits_left - 1'b1;
        d.div_cnt = q.div_set;
      end
    end
  end

  // state register; all fields take constants under reset
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q <= '0;
      q.sel_s1 <= 1'b1;
      q.sel_s2 <= 1'b1;
      q.sel_prev <= 1'b1;
      q.ctrl <= sslf_pkg::CTRL_RESET;
      q.stage_off <= '1;
      q.upstream_serial_out <= sslf_pkg::UP_IDLE;
    end else begin
      q <= d;
    end
  end

  // command frames wait here for the decoder
  sslf_fifo #(
    .WIDTH(sslf_pkg::CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_in_valid(q.cmd_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(q.cmd_word),
    .o_out_valid(O_CMD_VALID),
    .i_out_ready(I_CMD_READY),
    .o_out_data(O_CMD_WORD)
  );

  // outputs straight from flops
  assign O_UPSTREAM_SERIAL_OUT = q.upstream_serial_out;
  assign O_CMD_FIFO_READY = fifo_in_ready;
  assign O_UP_BUSY = q.tx_busy;
  assign O_STAGE_OFF = q.stage_off;
  assign O_OUTPUT_STAGE_CONTROL = q.ctrl;
  assign O_LINK_MON_FAIL = q.mon_fail;

  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  a_sdo_idle_high: assert property (!q.tx_busy |-> q.upstream_serial_out)
    else $error("upstream line low while idle");
  a_up_frame_format: assert property (read_ok |=> (q.tx_shift[0] == 1'b0)
    && (q.tx_shift[12:10] == 3'h7) && (q.bits_left == 4'hD))
    else $error("upstream frame layout wrong");
  a_up_parity_even: assert property (read_ok |=> !(^q.tx_shift[9:1]))
    else $error("upstream parity not even");
  a_start_bit_soon: assert property ($rose(q.tx_busy) |-> ##[1:80] $fell(q.upstream_serial_out))
    else $error("start bit late");
  a_busy_read_ignored: assert property (q.tx_busy && I_READ_REQ && !link_fall
    |=> $stable(q.tx_shift) && $stable(q.bits_left))
    else $error("read accepted while busy");
  a_data_frame_write: assert property (data_ok |=> q.ctrl == $past(q.shift))
    else $error("data frame not stored");
  a_bad_len_ignored: assert property (sel_rise && !len_ok && !sup_expire
    |=> $stable(q.ctrl) && !q.cmd_push)
    else $error("wrong length frame used");
  a_stage_mapping: assert property ($past(I_RST_N) |-> q.stage_off[0] == $past(q.ctrl[1])
    && q.stage_off[16] == $past(q.ctrl[8]) && q.stage_off[1] == $past(q.ctrl[9])
    && q.stage_off[17] == $past(q.ctrl[16]))
    else $error("stage mapping wrong");
  // first edge after release still shows the reset value, so skip it
  a_delayed_stages: assert property ($past(I_RST_N)
    |-> q.stage_off[15:14] == $past(I_DELAYED_STAGES_OFF))
    else $error("stages 15/16 not from command path");
  a_superv_expiry: assert property (sup_expire && !data_ok
    |=> q.mon_fail && (q.ctrl[16:1] == 16'hFFFF))
    else $error("supervision expiry not handled");

  c_data_frame: cover property (data_ok);
  c_cmd_frame: cover property (q.cmd_push && fifo_in_ready);
  c_read_done: cover property ($fell(q.tx_busy));
  c_expiry: cover property (sup_expire);
endmodule // sslf_link

// ---- sim/sslf_mcu_model.sv ----
`timescale 1ns/1ps
// behavioural link controller: free clock, framed select and data, upstream receiver
module sslf_mcu_model (
  // link pins
  output logic o_link_clk,
  output logic o_select_n,
  output logic o_data,
  input wire logic i_up
);
  localparam int HALF_NS = 50; // 10 MHz link clock
  // link clock toggles continuously, frames or not
  initial begin
    o_link_clk = 1'b0;
    forever #HALF_NS o_link_clk = ~o_link_clk;
  end
  // idle levels follow the pull-ups on select and data
  initial begin
    o_select_n = 1'b1;
    o_data = 1'b1;
  end
  // send n bits, first bit is the selection bit
  task automatic send(input logic [17:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge o_link_clk);
      #1;
      o_select_n = 1'b0;
      o_data = bits[i];
    end
    // n falling edges fall inside the active phase
    @(posedge o_link_clk);
    #1;
    o_select_n = 1'b1;
    o_data = 1'b1;
    // passive phase longer than two clocks
    repeat (3) @(posedge o_link_clk);
  endtask
  // receive one upstream frame, sampling mid-bit; high reads as one
  task automatic recv(input int div, output logic [12:0] f, output logic seen);
    int k;
    k = 0;
    while (i_up !== 1'b0 && k < 1000) begin
      #10;
      k++;
    end
    seen = (i_up === 1'b0);
    #((div + 1) * HALF_NS);
    for (int b = 0; b < 13; b++) begin
      f[b] = i_up;
      #((div + 1) * 2 * HALF_NS);
    end
  endtask
endmodule // sslf_mcu_model

// ---- sim/test_sslf_link.sv ----
`timescale 1ns/1ps
// self-checking bench for the serial link frame block
module test_sslf_link;
  localparam int SUPERV = 3000; // shortened supervision span
  logic clk, rst_n, link_clk, sel_n, sdata, upstream_serial_out;
  logic cmd_valid, cmd_ready, fifo_ready, read_req, up_busy, mon_clr, mon_fail;
  logic [15:0] cmd_word;
  logic [7:0] read_byte, b;
  logic [3:0] up_div;
  logic [1:0] dly_off;
  logic [17:0] stage_off;
  logic [16:0] ctrl;
  logic [12:0] f;
  logic [15:0] pl [4]; // data frame payloads
  logic seen;
  int n_mismatch, checks, n, k;
  sslf_mcu_model m (.o_link_clk(link_clk), .o_select_n(sel_n), .o_data(sdata), .i_up(upstream_serial_out));
  sslf_link #(.SUPERV_CYCLES(SUPERV), .FIFO_DEPTH(32)) i_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_DOWNSTREAM_CLOCK_IN(link_clk),
    .I_FRAME_SELECT_SYNC(sel_n), .I_SERIAL_DATA_IN(sdata), .O_UPSTREAM_SERIAL_OUT(upstream_serial_out),
    .O_CMD_VALID(cmd_valid), .I_CMD_READY(cmd_ready), .O_CMD_WORD(cmd_word),
    .O_CMD_FIFO_READY(fifo_ready), .I_READ_REQ(read_req), .I_READ_BYTE(read_byte),
    .I_UP_CLK_DIV(up_div), .O_UP_BUSY(up_busy), .I_DELAYED_STAGES_OFF(dly_off),
    .O_STAGE_OFF(stage_off), .O_OUTPUT_STAGE_CONTROL(ctrl), .I_MON_FAIL_CLR(mon_clr),
    .O_LINK_MON_FAIL(mon_fail));
  // system clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checks++;
    if (seen_v !== exp_v) begin
      n_mismatch++;
      $display("BAD %0t seen %0h expected %0h", $time, seen_v, exp_v);
    end
  endtask
  // verdict and end of run
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // stage-off vector expected for a data frame payload
  function automatic logic [17:0] exp_off(input logic [15:0] p, input logic [1:0] d);
    logic [17:0] e;
    e = '0;
    for (int j = 0; j < sslf_pkg::HALF_BITS; j++) begin
      e[sslf_pkg::ODD_STAGE[j]-1] = p[j];
      e[sslf_pkg::EVEN_STAGE[j]-1] = p[j+8];
    end
    e[14] = d[0];
    e[15] = d[1];
    return e;
  endfunction
  // register and stage outputs after a data frame
  task automatic check_ctrl(input logic [15:0] p);
    chk(32'(ctrl), 32'({p, 1'b0}));
    chk(32'(stage_off), 32'(exp_off(p, dly_off)));
  endtask
  // one-cycle read request
  task automatic read(input logic [7:0] v);
    @(posedge clk);
    #1;
    read_req = 1'b1;
    read_byte = v;
    @(posedge clk);
    #1;
    read_req = 1'b0;
  endtask
  // one-cycle clear pulse of the supervision flag
  task automatic clear_fail;
    @(posedge clk);
    #1;
    mon_clr = 1'b1;
    @(posedge clk);
    #1;
    mon_clr = 1'b0;
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    cmd_ready = 1'b0;
    read_req = 1'b0;
    read_byte = 8'h00;
    up_div = 4'h0;
    dly_off = 2'b10;
    mon_clr = 1'b0;
    n_mismatch = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(32'(ctrl), 32'(sslf_pkg::CTRL_RESET));
    chk(32'({stage_off, upstream_serial_out, up_busy, fifo_ready, cmd_valid, mon_fail}), 32'h0077FFF4);
    // payloads with no parity, halves distinct except in the all-zero one
    pl = '{16'hA53C, 16'h0001, 16'h8000, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      dly_off = (i % 2 == 1) ? 2'b01 : 2'b10;
      m.send({1'b0, pl[i], 1'b0}, 17);
      check_ctrl(pl[i]);
    end
    // frames one short and one long leave the register alone
    m.send({2'b01, 16'hFFFF}, 16);
    m.send({1'b0, 16'hFFFF, 1'b0}, 18);
    check_ctrl(16'h0000);
    // a command frame goes to the queue, not the register
    m.send({1'b0, 16'h1234, 1'b1}, 17);
    check_ctrl(16'h0000);
    chk(32'({cmd_valid, cmd_word}), 32'h11234);
    cmd_ready = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    cmd_ready = 1'b0;
    chk(32'(cmd_valid), 32'h0);
    // reads: second request while busy is dropped, data frame still lands
    for (int r = 0; r < 2; r++) begin
      up_div = r ? 4'h0 : 4'h2;
      b = r ? 8'h80 : 8'h6B;
      read(b);
      @(posedge clk);
      #1;
      chk(32'(up_busy), 32'h1);
      fork
        m.recv(int'(up_div), f, seen);
        begin
          repeat (20) @(posedge clk);
          read(~b);
          up_div = 4'h5;
          m.send({1'b0, 16'h5A0F, 1'b0}, 17);
        end
      join
      check_ctrl(16'h5A0F);
      chk(32'(seen), 32'h1);
      chk(32'(f), 32'({3'b111, ^b, b, 1'b0}));
      for (k = 0; k < 400 && up_busy !== 1'b0; k++) @(posedge clk);
      #1;
      repeat (100) @(posedge clk);
      chk(32'({up_busy, upstream_serial_out}), 32'h1);
    end
    // fill the command queue with the reader stalled, then drain it
    n = 0;
    while (fifo_ready === 1'b1 && n < 40) begin
      m.send({1'b0, 16'(n), 1'b1}, 17);
      n++;
    end
    chk(32'(n), 32'd32);
    m.send({1'b0, 16'hDEAD, 1'b1}, 17);
    cmd_ready = 1'b1;
    n = 0;
    for (k = 0; k < 100; k++) begin
      if (cmd_valid === 1'b1) begin
        chk(32'(cmd_word), 32'(n));
        n++;
      end
      @(posedge clk);
      #1;
    end
    chk(32'(n), 32'd32);
    // supervision: silence forces stages off, next data frame restores
    clear_fail;
    m.send({1'b0, 16'h1111, 1'b0}, 17);
    chk(32'(mon_fail), 32'h0);
    repeat (2800) @(posedge clk);
    #1;
    chk(32'(mon_fail), 32'h0);
    repeat (300) @(posedge clk);
    #1;
    chk(32'(mon_fail), 32'h1);
    check_ctrl(16'hFFFF);
    m.send({1'b0, 16'h2222, 1'b0}, 17);
    check_ctrl(16'h2222);
    clear_fail;
    chk(32'(mon_fail), 32'h0);
    results;
  end
  // watchdog well past the expected run length
  initial begin
    #500000;
    n_mismatch++;
    results;
  end
endmodule // test_sslf_link
